/* logic/srx_pkg.sv */
package srx_pkg;
  localparam logic [11:0] ADDR_RX_BYTE = 12'h000;
  localparam logic [11:0] ADDR_TX_BYTE = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_PENDING = 12'h00c;
  localparam logic [11:0] ADDR_ENABLE = 12'h010;
  localparam logic [11:0] ADDR_CONTROL = 12'h014;
  localparam int BIT_TX_READY = 4;
  localparam int BIT_RX_READY = 3;
  localparam int BIT_TX_OVERRUN = 2;
  localparam int BIT_RX_OVERRUN = 1;
  localparam int BIT_MODE_FAULT = 0;
  localparam int CTL_LSB_FIRST = 0;
  localparam int CTL_MASTER = 1;
  localparam logic [4:0] IRQ_RESET = 5'h00;
  localparam logic [1:0] CTL_RESET = 2'h0;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam int BITS_PER_BYTE = 8;
endpackage : srx_pkg

/* logic/srx_sync.sv */
module srx_sync #(
  parameter int WIDTH = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;
  // Two stages; first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule : srx_sync

/* logic/srx_shift.sv */
module srx_shift (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sample,
  input wire logic frame_start,
  input wire logic data_bit,
  input wire logic lsb_first,
  output logic byte_done,
  output logic [7:0] byte_out
);
  logic [7:0] shreg;
  logic [2:0] count;
  logic [7:0] next_shreg;
  logic [2:0] last_count;
  assign last_count = 3'(srx_pkg::BITS_PER_BYTE - 1);
  // Msb-first shifts left so last bit lands in bit 0; lsb-first shifts right
  assign next_shreg = lsb_first ? {data_bit, shreg[7:1]} : {shreg[6:0], data_bit};
  // Bit counter restarts at every select assertion so a torn byte never leaks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shreg <= srx_pkg::BYTE_RESET;
      count <= 3'h0;
      byte_done <= 1'b0;
      byte_out <= srx_pkg::BYTE_RESET;
    end else begin
      byte_done <= 1'b0;
      if (frame_start) begin
        count <= 3'h0;
      end else if (sample) begin
        shreg <= next_shreg;
        count <= count + 3'h1;
        if (count == last_count) begin
          byte_done <= 1'b1;
          byte_out <= next_shreg;
        end
      end
    end
  end
endmodule : srx_shift

/* logic/srx_top.sv */
// The register offsets and register access over APB were chosen for this implementation.
module srx_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic spi_sck,
  input wire logic spi_csn,
  input wire logic spi_mosi,
  input wire logic tx_byte_taken,
  output logic irq,
  output logic [7:0] tx_byte,
  output logic tx_byte_valid
);
  logic sck_s;
  logic csn_s;
  logic mosi_s;
  logic sck_d;
  logic csn_d;
  logic sample;
  logic frame_start;
  logic byte_done;
  logic [7:0] shift_byte;
  logic [7:0] rx_byte;
  logic rx_ready_flag;
  logic tx_ready_flag;
  logic rx_overrun_flag;
  logic tx_overrun_flag;
  logic mode_fault_flag;
  logic [4:0] flags;
  logic [4:0] flags_d;
  logic [4:0] rise;
  logic [4:0] pending;
  logic [4:0] irq_on;
  logic [1:0] control;
  logic [4:0] next_pending;

  srx_sync #(.WIDTH(3)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({spi_sck, spi_csn, spi_mosi}),
    .sync_out({sck_s, csn_s, mosi_s})
  );

  // Edge history of synchronised pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_d <= 1'b0;
      csn_d <= 1'b1;
    end else begin
      sck_d <= sck_s;
      csn_d <= csn_s;
    end
  end

  // Mode 0 slave: sample on sck rise inside an active frame
  assign sample = sck_s && !sck_d && !csn_s;
  assign frame_start = csn_d && !csn_s;

  srx_shift u_shift (
    .pclk(pclk),
    .presetn(presetn),
    .sample(sample),
    .frame_start(frame_start),
    .data_bit(mosi_s),
    .lsb_first(control[srx_pkg::CTL_LSB_FIRST]),
    .byte_done(byte_done),
    .byte_out(shift_byte)
  );

  // Bus decode
  logic acc;
  logic wr;
  logic rd;
  logic hit_rx;
  logic hit_tx;
  logic hit_st;
  logic hit_pend;
  logic hit_en;
  logic hit_ctl;
  logic hit_any;
  logic rx_read;
  logic tx_write;
  logic ctl_write;
  logic [31:0] next_prdata;
  assign acc = psel && penable && !pready;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign hit_rx = paddr == srx_pkg::ADDR_RX_BYTE;
  assign hit_tx = paddr == srx_pkg::ADDR_TX_BYTE;
  assign hit_st = paddr == srx_pkg::ADDR_STATUS;
  assign hit_pend = paddr == srx_pkg::ADDR_PENDING;
  assign hit_en = paddr == srx_pkg::ADDR_ENABLE;
  assign hit_ctl = paddr == srx_pkg::ADDR_CONTROL;
  assign hit_any = hit_rx | hit_tx | hit_st | hit_pend | hit_en | hit_ctl;
  assign rx_read = rd && hit_rx;
  assign tx_write = wr && hit_tx;
  assign ctl_write = wr && hit_ctl;

  // Read mux; unused upper bits and reserved bits 7..5 return zero
  assign next_prdata =
    hit_rx ? {24'h000000, rx_byte} :
    hit_st ? {27'h0000000, flags} :
    hit_pend ? {27'h0000000, pending} :
    hit_en ? {27'h0000000, irq_on} :
    hit_ctl ? {30'h00000000, control} : 32'h00000000;

  // One wait state: pready rises the cycle after access phase starts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= acc;
      pslverr <= acc && !hit_any;
      prdata <= rd ? next_prdata : 32'h00000000;
    end
  end

  // Receive holding register and its flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_byte <= srx_pkg::BYTE_RESET;
      rx_ready_flag <= 1'b0;
      rx_overrun_flag <= 1'b0;
    end else begin
      if (byte_done) begin
        rx_byte <= shift_byte;
        rx_ready_flag <= 1'b1;
        // Unread byte overwritten: previous data is lost
        if (rx_ready_flag && !rx_read) begin
          rx_overrun_flag <= 1'b1;
        end
      end else if (rx_read) begin
        rx_ready_flag <= 1'b0;
        rx_overrun_flag <= 1'b0;
      end
    end
  end

  // Transmit holding register handed to the shifter outside this block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_byte <= srx_pkg::BYTE_RESET;
      tx_byte_valid <= 1'b0;
      tx_overrun_flag <= 1'b0;
    end else begin
      if (tx_write) begin
        tx_byte <= pwdata[7:0];
        tx_byte_valid <= 1'b1;
        if (tx_byte_valid && !tx_byte_taken) begin
          tx_overrun_flag <= 1'b1;
        end
      end else if (tx_byte_taken) begin
        tx_byte_valid <= 1'b0;
      end
      if (wr && hit_st) begin
        tx_overrun_flag <= 1'b0;
      end
    end
  end
  assign tx_ready_flag = !tx_byte_valid;

  // Control and mode fault; fault set wins over a same-cycle control write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control <= srx_pkg::CTL_RESET;
      mode_fault_flag <= 1'b0;
    end else begin
      if (ctl_write) begin
        control <= pwdata[1:0];
      end
      if (frame_start && control[srx_pkg::CTL_MASTER]) begin
        mode_fault_flag <= 1'b1;
      end else if (ctl_write) begin
        mode_fault_flag <= 1'b0;
      end
    end
  end

  assign flags = {tx_ready_flag, rx_ready_flag, tx_overrun_flag, rx_overrun_flag,
                  mode_fault_flag};
  assign rise = flags & ~flags_d;
  // Rising flag with enable on sets; new set beats a same-cycle write-one clear
  assign next_pending = (pending & ~((wr && hit_pend) ? pwdata[4:0] : 5'h00))
                        | (rise & irq_on);

  // Enable register and sticky pending bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_d <= 5'h10; // Idle levels: transmit register empty, so no false edge after reset
      pending <= srx_pkg::IRQ_RESET;
      irq_on <= srx_pkg::IRQ_RESET;
      irq <= 1'b0;
    end else begin
      flags_d <= flags;
      pending <= next_pending;
      if (wr && hit_en) begin
        irq_on <= pwdata[4:0];
      end
      irq <= |next_pending;
    end
  end
endmodule : srx_top

/* tb/srx_checker.sv */
module srx_checker (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic tx_byte_taken,
  input logic irq,
  input logic [7:0] tx_byte,
  input logic tx_byte_valid
);
  // Completed read, taken write and the two interrupt register selects
  wire rd = pready && !pslverr && !pwrite;
  wire acc = psel && penable && !pready && pwrite;
  wire pa = paddr == srx_pkg::ADDR_PENDING;
  wire ea = paddr == srx_pkg::ADDR_ENABLE;
  logic [4:0] en_copy;
  // Own copy of the mask, so readback is judged against what was written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) en_copy <= 5'h00;
    else if (acc && ea) en_copy <= pwdata[4:0];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_rx_upper_zero: assert property (
    rd && paddr == srx_pkg::ADDR_RX_BYTE |-> prdata[31:8] == 24'h000000)
    else $error("receive read has upper bits set");
  a_reserved_read_zero: assert property ((rd && (pa || ea)) |-> prdata[31:5] == 27'h0)
    else $error("reserved interrupt bits read nonzero");
  a_refused_read_zero: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("refused access returned data");
  a_tx_write_loads: assert property (
    pready && pwrite && paddr == srx_pkg::ADDR_TX_BYTE |-> tx_byte_valid && tx_byte == pwdata[7:0])
    else $error("transmit write not loaded");
  a_taken_empties: assert property (tx_byte_taken && !penable |=> !tx_byte_valid)
    else $error("transmit register still full after take");
  a_status_tx_ready: assert property (
    rd && paddr == srx_pkg::ADDR_STATUS |-> prdata[4] == !tx_byte_valid)
    else $error("transmit ready disagrees with register state");
  a_pending_sticky: assert property (
    $fell(irq) |-> $past(acc && pa) || $past(acc && pa, 2) || $past(acc && pa, 3))
    else $error("interrupt dropped without clear");
  a_enable_readback: assert property (rd && ea |-> prdata[4:0] == en_copy)
    else $error("enable mask readback differs");
endmodule : srx_checker

bind srx_top srx_checker chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .tx_byte_taken, .irq, .tx_byte, .tx_byte_valid);

/* tb/srx_spi_master.sv */
module srx_spi_master (
  output logic spi_sck,
  output logic spi_csn,
  output logic spi_mosi
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle: clock stands low, device deselected
  initial begin
    spi_sck = 1'b0;
    spi_csn = 1'b1;
    spi_mosi = 1'b0;
  end
  // One byte, first bit b[7]; select wraps the whole string
  task automatic frame(input logic [7:0] b);
    spi_csn = 1'b0;
    #125;
    for (int i = 7; i >= 0; i--) begin
      spi_mosi = b[i];
      #62.5 spi_sck = 1'b1;
      #62.5 spi_sck = 1'b0;
    end
    #125 spi_csn = 1'b1;
    spi_mosi = ~spi_mosi; // Released line must not look held
  endtask : frame
endmodule : srx_spi_master

/* tb/test_spi_receive_and_interrupt_logic.sv */
module test_spi_receive_and_interrupt_logic;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, irq, rerr;
  logic tx_byte_taken, tx_byte_valid, spi_sck, spi_csn, spi_mosi;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [7:0] tx_byte;
  int err_total = 0;
  int compares = 0;
  always #5 pclk = ~pclk;
  srx_spi_master sp_u (.spi_sck, .spi_csn, .spi_mosi);
  srx_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .spi_sck, .spi_csn, .spi_mosi, .tx_byte_taken, .irq, .tx_byte, .tx_byte_valid);
  // One APB transfer; answer taken at the rising edge that sees pready high
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
    if (pready !== 1'b1) begin
      err_total++;
      $display("mismatch %0t bus answer timed out", $time);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : bus
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic close_out;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  // Watchdog: the sequence needs well under a tenth of this
  initial begin
    #300000;
    err_total++;
    close_out;
  end
  initial begin
    {presetn, psel, penable, pwrite, tx_byte_taken} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    bus(0, srx_pkg::ADDR_ENABLE, 0); chk(rdat, 0);
    bus(0, 12'h018, 0); chk({rdat[30:0], rerr}, 1);
    $display("test regs done");
    sp_u.frame(8'ha5);
    bus(0, srx_pkg::ADDR_RX_BYTE, 0); chk(rdat, 32'ha5);
    bus(0, srx_pkg::ADDR_PENDING, 0); chk(rdat, 0);
    bus(1, srx_pkg::ADDR_ENABLE, 32'hff);
    bus(1, srx_pkg::ADDR_CONTROL, 1);
    bus(0, srx_pkg::ADDR_ENABLE, 0); chk(rdat, 32'h1f);
    sp_u.frame(8'h1e);
    bus(0, srx_pkg::ADDR_RX_BYTE, 0); chk(rdat, 32'h78);
    bus(0, srx_pkg::ADDR_PENDING, 0); chk({rdat[30:0], irq}, 32'h11);
    bus(1, srx_pkg::ADDR_PENDING, 32'hff);
    bus(0, srx_pkg::ADDR_PENDING, 0); chk({rdat[30:0], irq}, 0);
    $display("test rx done");
    sp_u.frame(8'h01);
    sp_u.frame(8'h02);
    bus(0, srx_pkg::ADDR_RX_BYTE, 0); chk(rdat, 32'h40);
    bus(0, srx_pkg::ADDR_PENDING, 0); chk(rdat, 32'h0a);
    bus(1, srx_pkg::ADDR_PENDING, 32'hff);
    $display("test overrun done");
    bus(1, srx_pkg::ADDR_TX_BYTE, 32'h5a);
    bus(0, srx_pkg::ADDR_STATUS, 0); chk(rdat & 32'h10, 0);
    @(posedge pclk) tx_byte_taken <= 1'b1;
    @(posedge pclk) tx_byte_taken <= 1'b0;
    bus(0, srx_pkg::ADDR_PENDING, 0); chk(rdat, 32'h10);
    bus(1, srx_pkg::ADDR_PENDING, 32'hff);
    $display("test tx done");
    bus(1, srx_pkg::ADDR_CONTROL, 2);
    sp_u.frame(8'h00);
    bus(0, srx_pkg::ADDR_PENDING, 0); chk(rdat & 32'h1, 1);
    $display("test fault done");
    close_out;
  end
endmodule : test_spi_receive_and_interrupt_logic
